// >>> hdl/i2cse_consts.svh
`ifndef I2CSE_CONSTS_SVH
`define I2CSE_CONSTS_SVH

// bits per byte and the acknowledge slot index
`define I2CSE_DATA_BITS 4'd8
`define I2CSE_LAST_DATA 4'd7
`define I2CSE_ACK_SLOT 4'd8
// bit counter between a start and the scl fall that closes it
`define I2CSE_PRE_BIT 4'hf
// fixed upper pattern of a ten-bit first address byte
`define I2CSE_TEN_HI 5'b11110
// general call address, write direction
`define I2CSE_GC_ADDR 8'h00
// reset values
`define I2CSE_RST_BYTE 8'h00
`define I2CSE_RST_TX 8'hff
// transmit fifo defaults
`define I2CSE_FIFO_WIDTH 8
`define I2CSE_FIFO_DEPTH 16

`endif

// >>> hdl/i2cse_pkg.sv
package i2cse_pkg;

	typedef enum logic [2:0] {
		I2CSE_IDLE,
		I2CSE_ADDR,
		I2CSE_ADDR10,
		I2CSE_RX,
		I2CSE_TX
	} i2cse_state_t;

endpackage

// >>> hdl/i2cse_slave.sv
`timescale 1ns/1ps
// Functional notes
// - read address match: ack, enter transmit, hold scl if tx buffer empty until software sets release
// - transmit shifts 8 bits, sda changes on scl falling edges
// - transmit event pulse at ninth falling edge regardless of master ack
// - write address match: receive, sample on rising scl, load buffer, ack
// - buffer still full: no ack, buffer kept, event still pulsed
// - overflow set but buffer empty: buffer loaded, no ack
// - ten-bit first byte 11110 plus addr 9:8, write: event, clear match flag
// - second ten-bit byte matches addr 7:0: event, set match flag
// - ten-bit mismatch or early read direction: clear flag, go idle
// - after full ten-bit match, repeated start with read enters transmit
// - transmit: ack at ninth fall with empty tx buffer clears release
// - tx byte loaded before ninth fall: release stays set, no stretch
// - receive with stretch enabled and buffer full: clear release at ninth fall
// - software sets release anytime; early buffer read avoids stretching
// - ten-bit with stretch enabled: stretch after address bytes and data
// - software clear holds scl only after falling edge and scl low
// - stretch disabled: software clears of release are ignored
// - master and slave event flags as one-cycle pulses
// - slew disable control passed out to the pad
// - accept-all mode treats every address as a match
// - general call enable also matches all-zero write address
// - general call: address byte into buffer, full set, master event
// - seven-bit mode compares addr 6:0 with shift 7:1, bit 0 direction
// - ten-bit mode control selects seven or ten-bit matching
// - after repeated start following full match, first byte with read suffices
`include "i2cse_consts.svh"

module i2cse_fifo #(
	parameter int WIDTH = `I2CSE_FIFO_WIDTH,
	parameter int DEPTH = `I2CSE_FIFO_DEPTH
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	wire push = in_valid_in & in_ready_out;
	wire pop = out_valid_out & out_ready_in;

	assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_data_out = mem[rd_q];

	always_ff @(posedge clk_sys_in)
	begin
		if (ce_in && push)
			mem[wr_q] <= in_data_in;
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			in_ready_out <= 1'b1;
			out_valid_out <= 1'b0;
		end
		else if (ce_in)
		begin
			wr_q <= push ? wr_q + 1'b1 : wr_q;
			rd_q <= pop ? rd_q + 1'b1 : rd_q;
			cnt_q <= cnt_d;
			in_ready_out <= cnt_d != DEPTH[AW:0];
			out_valid_out <= cnt_d != '0;
		end
	end
endmodule

module i2cse_slave
	import i2cse_pkg::*;
#(
	parameter int FIFO_DEPTH = `I2CSE_FIFO_DEPTH
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	input wire logic [9:0] own_addr_in,
	input wire logic ten_bit_addr_mode_in,
	input wire logic general_call_enable_in,
	input wire logic accept_all_addresses_in,
	input wire logic stretch_enable_in,
	input wire logic slew_disable_in,
	output logic slew_disable_out,
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_data_in,
	output logic tx_ready_out,
	output logic tx_buffer_full_out,
	input wire logic rx_read_in,
	output logic [7:0] rx_buffer_out,
	output logic rx_buffer_full_out,
	output logic rx_overflow_flag_out,
	input wire logic rx_overflow_clr_in,
	input wire logic clock_release_set_in,
	input wire logic clock_release_clr_in,
	output logic clock_release_out,
	output logic ten_bit_match_flag_out,
	output logic slave_event_flag_out,
	output logic master_event_flag_out
);
	logic [2:0] scl_sy_q;
	logic [2:0] sda_sy_q;
	i2cse_state_t state_q, state_d, nxt_q, nxt_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] shift_q, shift_d, tx_sh_q, tx_sh_d, tx_byte_q, tx_byte_d, rxb_q, rxb_d;
	logic rbf_q, rbf_d, ov_q, ov_d, tbf_q, tbf_d, rel_q, rel_d, ten_q, ten_d;
	logic prior_q, prior_d, ack_q, ack_d, mack_q, mack_d, loaded_q, loaded_d;
	logic evs_q, evs_d, evm_q, evm_d, st_q, st_d, sev_d, mev_d;
	logic hold_q, hold_d, low_q, low_d, drive_d;
	logic fifo_valid;
	logic [7:0] fifo_data;

	wire scl_s = scl_sy_q[1];
	wire sda_s = sda_sy_q[1];
	wire scl_rise = scl_s & ~scl_sy_q[2];
	wire scl_fall = ~scl_s & scl_sy_q[2];
	wire start_c = scl_s & scl_sy_q[2] & ~sda_s & sda_sy_q[2];
	wire stop_c = scl_s & scl_sy_q[2] & sda_s & ~sda_sy_q[2];
	wire tx_pop = fifo_valid & ~tbf_q;
	wire rw_bit = shift_q[0];
	wire m7 = shift_q[7:1] == own_addr_in[6:0];
	wire hi_ok = (shift_q[7:3] == `I2CSE_TEN_HI) && (shift_q[2:1] == own_addr_in[9:8]);
	wire lo_ok = shift_q == own_addr_in[7:0];
	wire gc_ok = general_call_enable_in && (shift_q == `I2CSE_GC_ADDR);

	i2cse_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.ce_in(ce_in),
		.in_valid_in(tx_valid_in),
		.in_data_in(tx_data_in),
		.in_ready_out(tx_ready_out),
		.out_valid_out(fifo_valid),
		.out_data_out(fifo_data),
		.out_ready_in(~tbf_q)
	);

	always_comb
	begin
		state_d = state_q;
		nxt_d = nxt_q;
		bit_d = bit_q;
		shift_d = shift_q;
		tx_sh_d = tx_sh_q;
		tx_byte_d = tx_byte_q;
		rxb_d = rxb_q;
		rbf_d = rbf_q;
		ov_d = ov_q;
		tbf_d = tbf_q;
		rel_d = rel_q;
		ten_d = ten_q;
		prior_d = prior_q;
		ack_d = ack_q;
		mack_d = mack_q;
		loaded_d = loaded_q;
		evs_d = evs_q;
		evm_d = evm_q;
		st_d = st_q;
		sev_d = 1'b0;
		mev_d = 1'b0;
		if (rx_read_in)
			rbf_d = 1'b0;
		if (rx_overflow_clr_in)
			ov_d = 1'b0;
		if (tx_pop)
		begin
			tbf_d = 1'b1;
			tx_byte_d = fifo_data;
		end
		if (start_c)
		begin
			state_d = I2CSE_ADDR;
			bit_d = `I2CSE_PRE_BIT;
			ack_d = 1'b0;
			loaded_d = 1'b0;
		end
		else if (stop_c)
		begin
			state_d = I2CSE_IDLE;
			prior_d = 1'b0;
			ack_d = 1'b0;
		end
		else if (state_q != I2CSE_IDLE)
		begin
			if (scl_rise && bit_q < `I2CSE_DATA_BITS)
				shift_d = {shift_q[6:0], sda_s};
			if (scl_rise && bit_q == `I2CSE_ACK_SLOT)
				mack_d = ~sda_s;
			// load the outgoing byte once written
			if (state_q == I2CSE_TX && bit_q == '0 && !loaded_q && tbf_q && !scl_s)
			begin
				tx_sh_d = tx_byte_q;
				tbf_d = 1'b0;
				loaded_d = 1'b1;
			end
			if (scl_fall && bit_q < `I2CSE_LAST_DATA)
			begin
				bit_d = bit_q + 4'd1;
				tx_sh_d = {tx_sh_q[6:0], 1'b0};
			end
			else if (scl_fall && bit_q == `I2CSE_LAST_DATA)
			begin
				bit_d = `I2CSE_ACK_SLOT;
				ack_d = 1'b0;
				st_d = 1'b0;
				evs_d = 1'b0;
				evm_d = 1'b0;
				case (state_q)
					I2CSE_ADDR:
					begin
						if (accept_all_addresses_in || (!ten_bit_addr_mode_in && m7))
						begin
							ack_d = 1'b1;
							evs_d = 1'b1;
							nxt_d = rw_bit ? I2CSE_TX : I2CSE_RX;
						end
						else if (gc_ok)
						begin
							ack_d = 1'b1;
							evm_d = 1'b1;
							rxb_d = shift_q;
							rbf_d = 1'b1;
							nxt_d = I2CSE_RX;
						end
						else if (ten_bit_addr_mode_in && hi_ok && !rw_bit)
						begin
							ack_d = 1'b1;
							evs_d = 1'b1;
							st_d = 1'b1;
							ten_d = 1'b0;
							nxt_d = I2CSE_ADDR10;
						end
						else if (ten_bit_addr_mode_in && hi_ok && prior_q)
						begin
							ack_d = 1'b1;
							evs_d = 1'b1;
							st_d = 1'b1;
							nxt_d = I2CSE_TX;
						end
						else
						begin
							if (ten_bit_addr_mode_in)
								ten_d = 1'b0;
							state_d = I2CSE_IDLE;
						end
					end
					I2CSE_ADDR10:
					begin
						if (lo_ok)
						begin
							ack_d = 1'b1;
							evs_d = 1'b1;
							st_d = 1'b1;
							ten_d = 1'b1;
							prior_d = 1'b1;
							nxt_d = I2CSE_RX;
						end
						else
						begin
							ten_d = 1'b0;
							state_d = I2CSE_IDLE;
						end
					end
					I2CSE_RX:
					begin
						if (!rbf_q)
						begin
							rxb_d = shift_q;
							rbf_d = 1'b1;
						end
						else
							ov_d = 1'b1;
						ack_d = !rbf_q && !ov_q;
						evs_d = 1'b1;
						nxt_d = I2CSE_RX;
					end
					default:
					begin
						evs_d = 1'b1;
						nxt_d = I2CSE_TX;
					end
				endcase
			end
			else if (scl_fall && bit_q == `I2CSE_ACK_SLOT)
			begin
				bit_d = '0;
				ack_d = 1'b0;
				loaded_d = 1'b0;
				sev_d = evs_q;
				mev_d = evm_q;
				state_d = nxt_q;
				if (st_q && stretch_enable_in)
					rel_d = 1'b0;
				if (nxt_q == I2CSE_RX && stretch_enable_in && rbf_d)
					rel_d = 1'b0;
				if (nxt_q == I2CSE_TX && state_q != I2CSE_TX && !tbf_d)
					rel_d = 1'b0;
				if (state_q == I2CSE_TX)
				begin
					if (!mack_q)
						state_d = I2CSE_IDLE;
					else if (!tbf_d)
						rel_d = 1'b0;
				end
			end
			else if (scl_fall && bit_q == `I2CSE_PRE_BIT)
				bit_d = '0;
		end
		if (clock_release_set_in)
			rel_d = 1'b1;
		else if (clock_release_clr_in && stretch_enable_in)
			rel_d = 1'b0;
		// hold only after a seen fall and low scl
		low_d = scl_fall ? 1'b1 : (scl_rise ? 1'b0 : low_q);
		hold_d = rel_d ? 1'b0 : (hold_q | (low_q & ~scl_s) | scl_fall);
		drive_d = (bit_d == `I2CSE_ACK_SLOT && ack_d) | (state_d == I2CSE_TX && loaded_d
			&& bit_d < `I2CSE_DATA_BITS && ~tx_sh_d[7]);
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			scl_sy_q <= 3'h7;
			sda_sy_q <= 3'h7;
		end
		else if (ce_in)
		begin
			scl_sy_q <= {scl_sy_q[1:0], scl_in};
			sda_sy_q <= {sda_sy_q[1:0], sda_in};
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state_q <= I2CSE_IDLE;
			nxt_q <= I2CSE_IDLE;
			bit_q <= '0;
			shift_q <= `I2CSE_RST_BYTE;
			tx_sh_q <= `I2CSE_RST_TX;
			tx_byte_q <= `I2CSE_RST_TX;
			rxb_q <= `I2CSE_RST_BYTE;
			{rbf_q, ov_q, tbf_q, ten_q, prior_q, ack_q, mack_q, loaded_q} <= 8'h00;
			{evs_q, evm_q, st_q, hold_q, low_q} <= 5'h00;
			rel_q <= 1'b1;
		end
		else if (ce_in)
		begin
			state_q <= state_d;
			nxt_q <= nxt_d;
			bit_q <= bit_d;
			shift_q <= shift_d;
			tx_sh_q <= tx_sh_d;
			tx_byte_q <= tx_byte_d;
			rxb_q <= rxb_d;
			{rbf_q, ov_q, tbf_q, ten_q, prior_q, ack_q, mack_q, loaded_q} <=
				{rbf_d, ov_d, tbf_d, ten_d, prior_d, ack_d, mack_d, loaded_d};
			{evs_q, evm_q, st_q, hold_q, low_q} <= {evs_d, evm_d, st_d, hold_d, low_d};
			rel_q <= rel_d;
		end
	end

	// registered outputs
	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			scl_oe_n_out <= 1'b1;
			sda_oe_n_out <= 1'b1;
			slave_event_flag_out <= 1'b0;
			master_event_flag_out <= 1'b0;
			slew_disable_out <= 1'b0;
		end
		else if (ce_in)
		begin
			scl_oe_n_out <= ~hold_d;
			sda_oe_n_out <= ~drive_d;
			slave_event_flag_out <= sev_d;
			master_event_flag_out <= mev_d;
			slew_disable_out <= slew_disable_in;
		end
	end

	assign tx_buffer_full_out = tbf_q;
	assign rx_buffer_out = rxb_q;
	assign rx_buffer_full_out = rbf_q;
	assign rx_overflow_flag_out = ov_q;
	assign clock_release_out = rel_q;
	assign ten_bit_match_flag_out = ten_q;
endmodule

// >>> verification/i2cse_monitor.sv
`timescale 1ns/1ps
module i2cse_monitor (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic scl_oe_n_out,
	input wire logic clock_release_out,
	input wire logic clock_release_set_in,
	input wire logic clock_release_clr_in,
	input wire logic stretch_enable_in,
	input wire logic slave_event_flag_out,
	input wire logic master_event_flag_out,
	input wire logic [7:0] rx_buffer_out,
	input wire logic rx_buffer_full_out,
	input wire logic rx_read_in,
	input wire logic slew_disable_in,
	input wire logic slew_disable_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!nrst_in);
	sequence s_held;
		!scl_oe_n_out && !clock_release_out;
	endsequence
	property p_sev;
		slave_event_flag_out |=> !slave_event_flag_out;
	endproperty
	a_sev: assert property (p_sev) else $error("slave event too long");
	property p_mev;
		master_event_flag_out |-> rx_buffer_out == 8'h00;
	endproperty
	a_mev: assert property (p_mev) else $error("master event without call byte");
	property p_slew;
		$past(nrst_in) |-> slew_disable_out == $past(slew_disable_in);
	endproperty
	a_slew: assert property (p_slew) else $error("slew control not passed");
	property p_set;
		clock_release_set_in |=> clock_release_out;
	endproperty
	a_set: assert property (p_set) else $error("release set lost");
	property p_ign;
		!stretch_enable_in && clock_release_clr_in && clock_release_out
			|=> clock_release_out || slave_event_flag_out;
	endproperty
	a_ign: assert property (p_ign) else $error("release clear not ignored");
	property p_cause;
		$fell(scl_oe_n_out) |-> !clock_release_out;
	endproperty
	a_cause: assert property (p_cause) else $error("scl held while released");
	property p_hold;
		s_held && !clock_release_set_in |=> !scl_oe_n_out;
	endproperty
	a_hold: assert property (p_hold) else $error("scl let go early");
	property p_keep;
		rx_buffer_full_out && !rx_read_in |=> $stable(rx_buffer_out);
	endproperty
	a_keep: assert property (p_keep) else $error("full buffer overwritten");
endmodule
bind i2cse_slave i2cse_monitor mon (
	.clk_sys_in, .nrst_in, .scl_oe_n_out, .clock_release_out, .clock_release_set_in,
	.clock_release_clr_in, .stretch_enable_in, .slave_event_flag_out,
	.master_event_flag_out, .rx_buffer_out, .rx_buffer_full_out, .rx_read_in,
	.slew_disable_in, .slew_disable_out
);

// >>> verification/i2cse_bfm.sv
`timescale 1ns/1ps
module i2cse_bfm (
	input wire logic clk_sys_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_out
);
	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic tk(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	task automatic start();
		sda_out = 1'b1;
		tk(2);
		scl_out = 1'b1;
		tk(4);
		sda_out = 1'b0;
		tk(4);
		scl_out = 1'b0;
		tk(2);
	endtask
	task automatic stop();
		sda_out = 1'b0;
		tk(2);
		scl_out = 1'b1;
		tk(4);
		sda_out = 1'b1;
		tk(4);
	endtask
	// sda moves only with scl low
	task automatic bit_io(input logic b, output logic r);
		int n;
		sda_out = b;
		tk(2);
		scl_out = 1'b1;
		n = 0;
		while (scl_in !== 1'b1 && n < 99)
		begin
			tk(1);
			n++;
		end
		tk(4);
		r = sda_in;
		scl_out = 1'b0;
		tk(2);
	endtask
	task automatic xfer(input logic [7:0] w, input logic na, output logic [7:0] rd,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(w[i], r);
			rd[i] = r;
		end
		bit_io(na, r);
		ack = ~r;
		tk(4);
	endtask
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic ms, md, tx_valid_in, rx_read_in, rx_overflow_clr_in, ak;
	logic ten_bit_addr_mode_in, general_call_enable_in, accept_all_addresses_in;
	logic stretch_enable_in, slew_disable_in, clock_release_set_in, clock_release_clr_in;
	logic [9:0] own_addr_in;
	logic [7:0] tx_data_in, rx_buffer_out, rd;
	logic scl_out, scl_oe_n_out, sda_out, sda_oe_n_out, slew_disable_out, tx_ready_out;
	logic tx_buffer_full_out, rx_buffer_full_out, rx_overflow_flag_out, clock_release_out;
	logic ten_bit_match_flag_out, slave_event_flag_out, master_event_flag_out;
	int error_cnt = 0;
	int checked = 0;
	int sev = 0;
	int mev = 0;
	int n;
	wire scl_in = ms & scl_oe_n_out;
	wire sda_in = md & sda_oe_n_out;
	always #25 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in)
	begin
		if (slave_event_flag_out === 1'b1)
			sev++;
		if (master_event_flag_out === 1'b1)
			mev++;
	end
	i2cse_bfm m (.clk_sys_in, .scl_in, .sda_in, .scl_out(ms), .sda_out(md));
	i2cse_slave #(.FIFO_DEPTH(16)) uut (
		.clk_sys_in, .nrst_in, .ce_in(1'b1), .scl_in, .scl_out, .scl_oe_n_out, .sda_in,
		.sda_out, .sda_oe_n_out, .own_addr_in, .ten_bit_addr_mode_in,
		.general_call_enable_in, .accept_all_addresses_in, .stretch_enable_in,
		.slew_disable_in, .slew_disable_out, .tx_valid_in, .tx_data_in, .tx_ready_out,
		.tx_buffer_full_out, .rx_read_in, .rx_buffer_out, .rx_buffer_full_out,
		.rx_overflow_flag_out, .rx_overflow_clr_in, .clock_release_set_in,
		.clock_release_clr_in, .clock_release_out, .ten_bit_match_flag_out,
		.slave_event_flag_out, .master_event_flag_out);
	task automatic test_done();
		if (error_cnt == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string w, input logic [9:0] s, input logic [9:0] e);
		checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", w, e, s);
		end
	endtask
	task automatic pulse(ref logic p);
		p = 1'b1;
		@(negedge clk_sys_in);
		p = 1'b0;
		@(negedge clk_sys_in);
	endtask
	task automatic wb(input logic [7:0] b, input logic e);
		m.xfer(b, 1'b1, rd, ak);
		chk("ack", 10'(ak), 10'(e));
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_sys_in);
		error_cnt++;
		test_done();
	end
	initial
	begin
		{tx_valid_in, rx_read_in, rx_overflow_clr_in, ten_bit_addr_mode_in,
			general_call_enable_in, accept_all_addresses_in, stretch_enable_in,
			slew_disable_in, clock_release_set_in, clock_release_clr_in} = '0;
		own_addr_in = 10'h052;
		tx_data_in = 8'h00;
		repeat (12) @(negedge clk_sys_in);
		nrst_in = 1'b1;
		@(negedge clk_sys_in);
		chk("rst", {scl_oe_n_out, sda_oe_n_out, clock_release_out, tx_ready_out,
			rx_buffer_full_out, rx_overflow_flag_out, ten_bit_match_flag_out}, 10'h078);
		chk("rxb", rx_buffer_out, 10'h000);
		slew_disable_in = 1'b1;
		m.start();
		wb(8'ha4, 1);
		wb(8'ha5, 1);
		chk("rxb", rx_buffer_out, 10'h0a5);
		wb(8'h5a, 0);
		chk("ovf", {rx_buffer_out, rx_overflow_flag_out}, 10'h14b);
		pulse(rx_read_in);
		wb(8'h66, 0);
		chk("rxb", rx_buffer_out, 10'h066);
		m.stop();
		chk("sev", 10'(sev), 10'd4);
		pulse(rx_read_in);
		pulse(rx_overflow_clr_in);
		m.start();
		wb(8'ha6, 0);
		m.stop();
		stretch_enable_in = 1'b1;
		m.start();
		wb(8'ha4, 1);
		wb(8'h11, 1);
		chk("hold", {clock_release_out, scl_oe_n_out}, 10'h000);
		pulse(rx_read_in);
		pulse(clock_release_set_in);
		chk("hold", {clock_release_out, scl_oe_n_out}, 10'h003);
		m.stop();
		pulse(clock_release_clr_in);
		chk("rel", {clock_release_out, scl_oe_n_out}, 10'h001);
		pulse(clock_release_set_in);
		stretch_enable_in = 1'b0;
		pulse(clock_release_clr_in);
		chk("rel", clock_release_out, 10'h001);
		general_call_enable_in = 1'b1;
		m.start();
		wb(8'h00, 1);
		chk("gc", {rx_buffer_full_out, rx_buffer_out}, 10'h100);
		chk("mev", 10'(mev), 10'd1);
		m.stop();
		pulse(rx_read_in);
		general_call_enable_in = 1'b0;
		accept_all_addresses_in = 1'b1;
		m.start();
		wb(8'hfc, 1);
		m.stop();
		accept_all_addresses_in = 1'b0;
		n = 0;
		tx_valid_in = 1'b1;
		while (tx_ready_out === 1'b1 && n < 20)
		begin
			tx_data_in = 8'h40 + 8'(n);
			@(negedge clk_sys_in);
			n++;
		end
		tx_valid_in = 1'b0;
		chk("fill", 10'(n), 10'd17);
		chk("tbf", tx_buffer_full_out, 10'h001);
		sev = 0;
		m.start();
		wb(8'ha5, 1);
		for (int i = 0; i < 17; i++)
		begin
			m.xfer(8'hff, i == 16, rd, ak);
			chk("tx", rd, 10'(8'h40 + 8'(i)));
			chk("rel", clock_release_out, 10'h001);
		end
		m.stop();
		chk("sev", 10'(sev), 10'd18);
		ten_bit_addr_mode_in = 1'b1;
		own_addr_in = 10'h2a5;
		sev = 0;
		m.start();
		wb(8'hf4, 1);
		chk("t10", ten_bit_match_flag_out, 10'h000);
		wb(8'ha5, 1);
		chk("t10", ten_bit_match_flag_out, 10'h001);
		m.start();
		wb(8'hf5, 1);
		chk("rel", clock_release_out, 10'h000);
		tx_data_in = 8'hc3;
		pulse(tx_valid_in);
		pulse(clock_release_set_in);
		m.xfer(8'hff, 1'b0, rd, ak);
		chk("tx", rd, 10'h0c3);
		chk("hold", {clock_release_out, scl_oe_n_out}, 10'h000);
		pulse(clock_release_set_in);
		m.stop();
		chk("sev", 10'(sev), 10'd4);
		m.start();
		wb(8'hf4, 1);
		wb(8'h5a, 0);
		chk("t10", ten_bit_match_flag_out, 10'h000);
		m.stop();
		stretch_enable_in = 1'b1;
		m.start();
		wb(8'hf4, 1);
		chk("st10", {clock_release_out, scl_oe_n_out}, 10'h000);
		pulse(clock_release_set_in);
		wb(8'ha5, 1);
		chk("st10", {clock_release_out, scl_oe_n_out}, 10'h000);
		pulse(clock_release_set_in);
		m.stop();
		m.start();
		wb(8'hf5, 0);
		chk("t10", ten_bit_match_flag_out, 10'h000);
		m.stop();
		test_done();
	end
endmodule
